// [hdl/cca_map.svh]
`ifndef CCA_MAP_SVH
`define CCA_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define CCA_CH1_CTL      8'hA4
`define CCA_CH2_CTL      8'hA5
`define CCA_CH3_CTL      8'hA6
`define CCA_CH4_CTL      8'hA7
`define CCA_CH1_HI       8'h9E
`define CCA_CH1_LO       8'h9F
`define CCA_CH2_HI       8'h91
`define CCA_CH2_LO       8'h92
`define CCA_CH3_HI       8'h93
`define CCA_CH3_LO       8'h94
`define CCA_CH4_HI       8'h95
`define CCA_CH4_LO       8'h96
`define CCA_CNT_HI       8'h9A
`define CCA_CNT_LO       8'h9B
`define CCA_RUN_CTL      8'hB0
`define CCA_IRQ_STATUS   8'hB1
`define CCA_IRQ_CLEAR    8'hB2
`define CCA_IRQ_ENABLE   8'hB3

// ****************************************
// fields and reset values
// ****************************************
`define CCA_TOG_BIT      4
`define CCA_MODE_MSB     2
`define CCA_RUN_BIT      0
`define CCA_CLKSEL_MSB   2
`define CCA_CLKSEL_LSB   1
`define CCA_RESET_BYTE   8'h00
`define CCA_RESET_WORD   16'h0000

// ****************************************
// mode codes and clock selections
// ****************************************
`define CCA_MODE_DIS     3'b000
`define CCA_MODE_RISE    3'b001
`define CCA_MODE_FALL    3'b010
`define CCA_MODE_BOTH    3'b011
`define CCA_MODE_TIMER   3'b100
`define CCA_MODE_HSO     3'b101
`define CCA_MODE_PWM8    3'b110
`define CCA_MODE_PWM16   3'b111
`define CCA_CLK_OSC      2'b00
`define CCA_CLK_DIV4     2'b01
`define CCA_CLK_DIV12    2'b10
`define CCA_CLK_EXT      2'b11
`define CCA_DIV4_LAST    4'h3
`define CCA_DIV12_LAST   4'hB

`endif

// [hdl/cca_pkg.sv]
`include "cca_map.svh"
package cca_pkg;

    typedef enum logic [2:0] {
        mode_dis   = `CCA_MODE_DIS,
        mode_rise  = `CCA_MODE_RISE,
        mode_fall  = `CCA_MODE_FALL,
        mode_both  = `CCA_MODE_BOTH,
        mode_timer = `CCA_MODE_TIMER,
        mode_hso   = `CCA_MODE_HSO,
        mode_pwm8  = `CCA_MODE_PWM8,
        mode_pwm16 = `CCA_MODE_PWM16
    } cca_mode_t;

    typedef struct packed {
        logic      toggle;
        cca_mode_t mode;
    } cca_chan_cfg_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cca_bus_req_t;

endpackage

// [hdl/cca_channel.sv]
`timescale 1ns/1ps
`include "cca_map.svh"
module cca_channel #(
    parameter int CNT_W = 16
) (
    input  wire logic                  clock,
    input  wire logic                  arst_n,
    input  wire cca_pkg::cca_chan_cfg_t cfg,
    input  wire logic [CNT_W-1:0]      counter,
    input  wire logic                  tick,
    input  wire logic                  cap_pin,
    input  wire logic                  wr_hi,
    input  wire logic                  wr_lo,
    input  wire logic [7:0]            wdata,
    output logic [CNT_W-1:0]           value,
    output logic                       event_hit,
    output logic                       out
);
    import cca_pkg::*;

    if (CNT_W != 16) begin : g_chk
        $error("cca_channel: value is split in two bytes, CNT_W must be 16");
    end

    // ****************************************
    // pin synchroniser and edge detect
    // ****************************************
    logic cap_s1;
    logic cap_s2;
    logic cap_s3;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cap_s1 <= 1'b0;
            cap_s2 <= 1'b0;
            cap_s3 <= 1'b0;
        end else begin
            cap_s1 <= cap_pin;
            cap_s2 <= cap_s1;
            cap_s3 <= cap_s2;
        end
    end

    wire rise      = cap_s2 & ~cap_s3;
    wire fall      = ~cap_s2 & cap_s3;
    wire cap_hit   = (cfg.mode == mode_rise & rise)
                   | (cfg.mode == mode_fall & fall)
                   | (cfg.mode == mode_both & (rise | fall));
    wire match     = tick & (counter == value);
    wire cmp_mode  = (cfg.mode == mode_timer) | (cfg.mode == mode_hso);
    wire cmp_hit   = cmp_mode & match;

    // ****************************************
    // value register
    // ****************************************
    // software write beats a capture in the same cycle
    logic [CNT_W-1:0] next_value;
    assign next_value = wr_hi   ? {wdata, value[7:0]} :
                        wr_lo   ? {value[15:8], wdata} :
                        cap_hit ? counter : value;

    // ****************************************
    // output pin
    // ****************************************
    logic next_out;
    always_comb begin
        next_out = 1'b0;
        unique case (cfg.mode)
            mode_hso: begin
                // toggle bit set: flip on match; clear: drive high
                if (match) begin
                    next_out = cfg.toggle ? ~out : 1'b1;
                end else begin
                    next_out = out;
                end
            end
            mode_pwm8:  next_out = counter[7:0] < value[7:0];
            mode_pwm16: next_out = counter < value;
            default:    next_out = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            value     <= `CCA_RESET_WORD;
            event_hit <= 1'b0;
            out       <= 1'b0;
        end else begin
            value     <= next_value;
            event_hit <= cap_hit | cmp_hit;
            out       <= next_out;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_disabled_quiet: assert property (
        cfg.mode == mode_dis |=> !event_hit && !out)
        else $error("disabled channel produced an event or output");
    a_rise_capture: assert property (
        cfg.mode == mode_rise && rise && !wr_hi && !wr_lo
        |=> event_hit && value == $past(counter))
        else $error("rising edge not captured");
    a_rise_only: assert property (
        cfg.mode == mode_rise && fall |=> !event_hit)
        else $error("falling edge captured in rising mode");
    a_fall_capture: assert property (
        cfg.mode == mode_fall && fall && !wr_hi && !wr_lo
        |=> event_hit && value == $past(counter))
        else $error("falling edge not captured");
    a_both_capture: assert property (
        cfg.mode == mode_both && (rise || fall) |=> event_hit)
        else $error("edge missed in both-edge mode");
    a_match_flag: assert property (
        cmp_mode && tick && counter == value |=> event_hit)
        else $error("compare match did not raise event");
    a_hso_toggle: assert property (
        cfg.mode == mode_hso && cfg.toggle && match |=> out != $past(out))
        else $error("high-speed output did not toggle");
    a_pwm16_level: assert property (
        cfg.mode == mode_pwm16 ##1 cfg.mode == mode_pwm16
        |-> out == ($past(counter) < $past(value)))
        else $error("16-bit pwm level wrong");

endmodule

// [hdl/cca_top.sv]
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "cca_map.svh"
module cca_top #(
    parameter int NUM_CH = 4,
    parameter int CNT_W  = 16
) (
    input  wire logic                  clock,
    input  wire logic                  arst_n,
    input  wire cca_pkg::cca_bus_req_t bus_req,
    output logic [7:0]                 rd_data,
    input  wire logic [NUM_CH-1:0]     cap_in,
    input  wire logic                  ext_clk_in,
    output logic [NUM_CH-1:0]          cmp_out,
    output logic                       irq
);
    import cca_pkg::*;

    if (NUM_CH != 4 || CNT_W != 16) begin : g_chk
        $error("cca_top: register map serves exactly 4 channels of 16 bits");
    end

    localparam logic [7:0] CTL_ADDR [4] = '{`CCA_CH1_CTL, `CCA_CH2_CTL,
                                            `CCA_CH3_CTL, `CCA_CH4_CTL};
    localparam logic [7:0] HI_ADDR  [4] = '{`CCA_CH1_HI, `CCA_CH2_HI,
                                            `CCA_CH3_HI, `CCA_CH4_HI};
    localparam logic [7:0] LO_ADDR  [4] = '{`CCA_CH1_LO, `CCA_CH2_LO,
                                            `CCA_CH3_LO, `CCA_CH4_LO};

    // ****************************************
    // address decode
    // ****************************************
    wire wr          = bus_req.wr;
    wire [7:0] addr  = bus_req.addr;
    wire [7:0] wdata = bus_req.wdata;

    wire run_wr  = wr & (addr == `CCA_RUN_CTL);
    wire clr_wr  = wr & (addr == `CCA_IRQ_CLEAR);
    wire en_wr   = wr & (addr == `CCA_IRQ_ENABLE);
    wire cnth_wr = wr & (addr == `CCA_CNT_HI);
    wire cntl_wr = wr & (addr == `CCA_CNT_LO);
    wire cnt_wr  = cnth_wr | cntl_wr;

    logic [NUM_CH-1:0] ctl_wr;
    logic [NUM_CH-1:0] hi_wr;
    logic [NUM_CH-1:0] lo_wr;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_dec
        assign ctl_wr[i] = wr & (addr == CTL_ADDR[i]);
        assign hi_wr[i]  = wr & (addr == HI_ADDR[i]);
        assign lo_wr[i]  = wr & (addr == LO_ADDR[i]);
    end

    // ****************************************
    // control registers
    // ****************************************
    cca_chan_cfg_t     cfg [NUM_CH];
    logic              run;
    logic [1:0]        clksel;
    logic [NUM_CH-1:0] status;
    logic [NUM_CH-1:0] enable;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_cfg
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                cfg[i] <= '{toggle: 1'b0, mode: mode_dis};
            end else if (ctl_wr[i]) begin
                // bits 7,6,5,3 have no storage
                cfg[i].toggle <= wdata[`CCA_TOG_BIT];
                cfg[i].mode   <= cca_mode_t'(wdata[`CCA_MODE_MSB:0]);
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            run    <= 1'b0;
            clksel <= `CCA_CLK_OSC;
            enable <= '0;
        end else begin
            if (run_wr) begin
                run    <= wdata[`CCA_RUN_BIT];
                clksel <= wdata[`CCA_CLKSEL_MSB:`CCA_CLKSEL_LSB];
            end
            if (en_wr) begin
                enable <= wdata[NUM_CH-1:0];
            end
        end
    end

    // ****************************************
    // counter clock source
    // ****************************************
    // external pin is sampled, so it must run below a quarter of clock
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end else begin
            ext_s1 <= ext_clk_in;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    wire ext_rise = ext_s2 & ~ext_s3;

    logic [3:0] pre_cnt;
    wire  [3:0] pre_last_val = (clksel == `CCA_CLK_DIV4)  ? `CCA_DIV4_LAST :
                               (clksel == `CCA_CLK_DIV12) ? `CCA_DIV12_LAST :
                               4'h0;
    wire pre_last = (pre_cnt == pre_last_val);
    wire src_tick = (clksel == `CCA_CLK_EXT) ? ext_rise : pre_last;
    wire tick     = run & src_tick & ~cnt_wr;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pre_cnt <= 4'h0;
        end else if (!run || pre_last) begin
            pre_cnt <= 4'h0;
        end else begin
            pre_cnt <= pre_cnt + 4'h1;
        end
    end

    // ****************************************
    // shared counter
    // ****************************************
    logic [CNT_W-1:0] counter;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            counter <= `CCA_RESET_WORD;
        end else if (cnth_wr) begin
            counter[15:8] <= wdata;
        end else if (cntl_wr) begin
            counter[7:0] <= wdata;
        end else if (tick) begin
            counter <= counter + 16'h0001;
        end
    end

    // ****************************************
    // channels
    // ****************************************
    logic [CNT_W-1:0]  value [NUM_CH];
    logic [NUM_CH-1:0] evt;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        cca_channel #(
            .CNT_W (CNT_W)
        ) u_ch (
            .clock     (clock),
            .arst_n    (arst_n),
            .cfg       (cfg[i]),
            .counter   (counter),
            .tick      (tick),
            .cap_pin   (cap_in[i]),
            .wr_hi     (hi_wr[i]),
            .wr_lo     (lo_wr[i]),
            .wdata     (wdata),
            .value     (value[i]),
            .event_hit (evt[i]),
            .out       (cmp_out[i])
        );
    end

    // ****************************************
    // interrupt flags
    // ****************************************
    // a new event in the clearing cycle survives: set wins
    wire [NUM_CH-1:0] clr_mask    = clr_wr ? wdata[NUM_CH-1:0] : '0;
    wire [NUM_CH-1:0] next_status = (status & ~clr_mask) | evt;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            status <= '0;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            irq    <= |(status & enable);
        end
    end

    // ****************************************
    // read path
    // ****************************************
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        for (int i = 0; i < NUM_CH; i++) begin
            if (addr == CTL_ADDR[i]) begin
                rd_mux = {3'b000, cfg[i].toggle, 1'b0, cfg[i].mode};
            end
            if (addr == HI_ADDR[i]) begin
                rd_mux = value[i][15:8];
            end
            if (addr == LO_ADDR[i]) begin
                rd_mux = value[i][7:0];
            end
        end
        unique case (addr)
            `CCA_CNT_HI:     rd_mux = counter[15:8];
            `CCA_CNT_LO:     rd_mux = counter[7:0];
            `CCA_RUN_CTL:    rd_mux = {5'b00000, clksel, run};
            `CCA_IRQ_STATUS: rd_mux = {4'h0, status};
            `CCA_IRQ_ENABLE: rd_mux = {4'h0, enable};
            default:         ;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= `CCA_RESET_BYTE;
        end else begin
            rd_data <= bus_req.rd ? rd_mux : `CCA_RESET_BYTE;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_counter_stop: assert property (
        !run && !cnt_wr |=> counter == $past(counter))
        else $error("counter moved while stopped");
    a_counter_osc: assert property (
        run && clksel == `CCA_CLK_OSC && !cnt_wr
        |=> counter == $past(counter) + 16'h0001)
        else $error("counter did not step on oscillator clock");
    a_div12_gap: assert property (
        tick && clksel == `CCA_CLK_DIV12 |=> !tick [*8])
        else $error("divide by 12 ticked too soon");
    a_flag_sticky: assert property (
        status[0] && !(clr_wr && wdata[0]) |=> status[0])
        else $error("channel flag cleared without software");
    a_flag_set: assert property (
        evt[0] |=> status[0])
        else $error("event lost from status");
    a_irq_level: assert property (
        |(status & enable) |=> irq)
        else $error("enabled flag did not raise irq");
    a_ctl_reserved: assert property (
        bus_req.rd && addr == `CCA_CH1_CTL |=> rd_data[7:5] == 3'b000 && !rd_data[3])
        else $error("reserved control bits read nonzero");

    // ****************************************
    // checks: reset and register bus
    // ****************************************
    // first edge out of reset must still show counter, run, status and channel 4 at reset
    a_reset_clean: assert property (
        $rose(arst_n) |-> counter == `CCA_RESET_WORD && !run && status == '0
                          && cfg[3] == '0 && value[3] == `CCA_RESET_WORD)
        else $error("state not at reset value after reset");
    a_rd_idle_zero: assert property (
        !bus_req.rd |=> rd_data == `CCA_RESET_BYTE)
        else $error("read data not zero outside a read");
    a_ctl_write: assert property (
        ctl_wr[0] |=> cfg[0].toggle == $past(wdata[`CCA_TOG_BIT])
                      && cfg[0].mode == $past(wdata[`CCA_MODE_MSB:0]))
        else $error("control write not stored");
    a_ctl_readback: assert property (
        bus_req.rd && addr == `CCA_CH4_CTL
        |=> rd_data == {3'b000, $past(cfg[3].toggle), 1'b0, $past(cfg[3].mode)})
        else $error("control byte read back wrong");
    a_hi_write: assert property (
        hi_wr[1] |=> value[1] == {$past(wdata), $past(value[1][7:0])})
        else $error("high byte write wrong");
    a_lo_write: assert property (
        lo_wr[2] |=> value[2] == {$past(value[2][15:8]), $past(wdata)})
        else $error("low byte write wrong");
    a_hi_read: assert property (
        bus_req.rd && addr == `CCA_CH2_HI |=> rd_data == $past(value[1][15:8]))
        else $error("high byte read wrong");
    a_lo_read: assert property (
        bus_req.rd && addr == `CCA_CH3_LO |=> rd_data == $past(value[2][7:0]))
        else $error("low byte read wrong");
    a_status_read: assert property (
        bus_req.rd && addr == `CCA_IRQ_STATUS |=> rd_data == {4'h0, $past(status)})
        else $error("status read wrong");

    // ****************************************
    // checks: counter and its clock
    // ****************************************
    // a counter write swallows the tick, so each step check excludes it
    a_run_write: assert property (
        run_wr |=> run == $past(wdata[`CCA_RUN_BIT])
                   && clksel == $past(wdata[`CCA_CLKSEL_MSB:`CCA_CLKSEL_LSB]))
        else $error("run control write not stored");
    a_pre_restart: assert property (
        !run || pre_last |=> pre_cnt == 4'h0)
        else $error("prescaler did not restart");
    a_div4_hold: assert property (
        run && clksel == `CCA_CLK_DIV4 && pre_cnt != `CCA_DIV4_LAST && !cnt_wr
        |=> counter == $past(counter))
        else $error("divide by 4 stepped between prescaler ends");
    a_div4_step: assert property (
        run && clksel == `CCA_CLK_DIV4 && pre_cnt == `CCA_DIV4_LAST && !cnt_wr
        |=> counter == $past(counter) + 16'h0001)
        else $error("divide by 4 missed its step");
    a_ext_step: assert property (
        run && clksel == `CCA_CLK_EXT && ext_rise && !cnt_wr
        |=> counter == $past(counter) + 16'h0001)
        else $error("external clock edge not counted");
    a_ext_hold: assert property (
        run && clksel == `CCA_CLK_EXT && !ext_rise && !cnt_wr
        |=> counter == $past(counter))
        else $error("counter moved without external edge");
    a_cnt_hi_write: assert property (
        cnth_wr |=> counter == {$past(wdata), $past(counter[7:0])})
        else $error("counter high byte write wrong");
    a_cnt_lo_write: assert property (
        cntl_wr |=> counter == {$past(counter[15:8]), $past(wdata)})
        else $error("counter low byte write wrong");
    a_cnt_read: assert property (
        bus_req.rd && addr == `CCA_CNT_LO |=> rd_data == $past(counter[7:0]))
        else $error("counter low byte read wrong");

    // ****************************************
    // checks: flags and interrupt
    // ****************************************
    a_flags_kept: assert property (
        1'b1 |=> (status & $past(status & ~clr_mask)) == $past(status & ~clr_mask))
        else $error("a flag fell without a clear");
    a_flag_clear: assert property (
        clr_wr && wdata[1] && !evt[1] |=> !status[1])
        else $error("clear did not drop the flag");
    a_events_kept: assert property (
        1'b1 |=> (status & $past(evt)) == $past(evt))
        else $error("event did not reach status");
    a_enable_write: assert property (
        en_wr |=> enable == $past(wdata[NUM_CH-1:0]))
        else $error("enable write not stored");
    a_irq_quiet: assert property (
        !(|(status & enable)) |=> !irq)
        else $error("irq high with no enabled flag");

endmodule

// [bench/cca_pins.sv]
`timescale 1ns/1ps
module cca_pins (
    input  wire logic clock,
    output logic [3:0] cap_in,
    output logic       ext_clk_in
);
    logic       ext_en = 1'b0;
    logic [1:0] div    = 2'd0;

    initial cap_in = 4'h0;
    initial ext_clk_in = 1'b0;

    // ********
    // capture pins
    // ********
    // held 8 clocks: sync, edge stage and flag all settle
    task automatic set_pin(input int ch, input logic lvl);
        @(posedge clock);
        cap_in[ch] <= lvl;
        repeat (8) @(posedge clock);
    endtask

    // ********
    // external count clock
    // ********
    // stands low unless enabled; period 8 clocks, slower than clock/4
    always @(posedge clock) begin
        div <= ext_en ? div + 2'd1 : 2'd0;
        if (!ext_en)
            ext_clk_in <= 1'b0;
        else if (div == 2'd3)
            ext_clk_in <= ~ext_clk_in;
    end
endmodule

// [bench/cca_top_tb.sv]
`timescale 1ns/1ps
`include "cca_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module cca_top_tb;
    import cca_pkg::*;

    logic         clock     = 1'b0;
    logic         arst_n    = 1'b0;
    cca_bus_req_t bus_req   = '0;
    logic [7:0]   rd_data;
    logic [3:0]   cap_in;
    logic         ext_clk_in;
    logic [3:0]   cmp_out;
    logic         irq;
    logic         rd_d      = 1'b0;
    logic [15:0]  exp_q[$];
    logic [15:0]  exp_w;
    logic [15:0]  b;
    int           err_count = 0;
    int           n_checks  = 0;
    logic [7:0]   ctl_a [4] = '{`CCA_CH1_CTL, `CCA_CH2_CTL, `CCA_CH3_CTL, `CCA_CH4_CTL};
    logic [7:0]   hi_a  [4] = '{`CCA_CH1_HI, `CCA_CH2_HI, `CCA_CH3_HI, `CCA_CH4_HI};
    logic [7:0]   lo_a  [4] = '{`CCA_CH1_LO, `CCA_CH2_LO, `CCA_CH3_LO, `CCA_CH4_LO};
    logic [15:0]  vals  [4] = '{16'h0020, 16'h0010, 16'hFF80, 16'h0100};
    logic [7:0]   mds   [4] = '{8'h04, 8'h15, 8'h06, 8'h07};
    int           cyc   [4] = '{10, 40, 120, 80};

    always #5 clock = ~clock;

    cca_top DUT (
        .clock      (clock),
        .arst_n     (arst_n),
        .bus_req    (bus_req),
        .rd_data    (rd_data),
        .cap_in     (cap_in),
        .ext_clk_in (ext_clk_in),
        .cmp_out    (cmp_out),
        .irq        (irq)
    );

    cca_pins pins (
        .clock      (clock),
        .cap_in     (cap_in),
        .ext_clk_in (ext_clk_in)
    );

    // ********
    // bus master and read monitor
    // ********
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus_req.wr <= 1'b0;
    endtask

    // note holds {mask, expected}; mask lets running counts land in a band
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        exp_q.push_back({m, e});
        @(posedge clock);
        bus_req.rd <= 1'b0;
    endtask

    always @(posedge clock) rd_d <= bus_req.rd;

    // read data stands only in the cycle after the strobe
    always @(negedge clock) begin
        if (rd_d) begin
            exp_w = exp_q.pop_front();
            `CHK(rd_data & exp_w[15:8], exp_w[7:0] & exp_w[15:8])
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #200_000;
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish;
    end

    // ********
    // tests
    // ********
    initial begin
        void'($urandom(32'he70f));
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(ctl_a[i], 8'h00);
            rd(hi_a[i], 8'h00);
            rd(lo_a[i], 8'h00);
        end
        rd(8'hC0, 8'h00);
        $display("test reset values done");

        for (int i = 0; i < 4; i++) begin
            b = 16'($urandom);
            wr(ctl_a[i], 8'hFF);
            rd(ctl_a[i], 8'h17);
            wr(ctl_a[i], 8'h00);
            wr(hi_a[i], b[15:8]);
            wr(lo_a[i], b[7:0]);
            rd(hi_a[i], b[15:8]);
            rd(lo_a[i], b[7:0]);
        end
        $display("test register layout done");

        // counter stopped so each capture value is known exactly
        wr(`CCA_IRQ_ENABLE, 8'h0F);
        for (int m = 0; m < 4; m++) begin
            wr(lo_a[m], 8'h00);
            wr(`CCA_CNT_LO, 8'(8'h40 + m));
            wr(ctl_a[m], {5'h00, 3'(m)});
            pins.set_pin(m, 1'b1);
            rd(`CCA_IRQ_STATUS, (m == 1 || m == 3) ? 8'(1 << m) : 8'h00);
            wr(`CCA_IRQ_CLEAR, 8'h0F);
            wr(`CCA_CNT_LO, 8'(8'h80 + m));
            pins.set_pin(m, 1'b0);
            rd(`CCA_IRQ_STATUS, (m >= 2) ? 8'(1 << m) : 8'h00);
            `CHK(irq, 1'(m >= 2))
            rd(lo_a[m], m == 0 ? 8'h00 : m == 1 ? 8'h41 : 8'(8'h80 + m));
            wr(`CCA_IRQ_ENABLE, 8'h00);
            repeat (2) @(posedge clock);
            `CHK(irq, 1'b0)
            wr(`CCA_IRQ_ENABLE, 8'h0F);
            wr(`CCA_IRQ_CLEAR, 8'h0F);
        end
        repeat (2) @(posedge clock);
        `CHK(irq, 1'b0)
        $display("test capture done");

        for (int i = 0; i < 4; i++) begin
            wr(hi_a[i], vals[i][15:8]);
            wr(lo_a[i], vals[i][7:0]);
            wr(ctl_a[i], mds[i]);
        end
        wr(`CCA_CNT_HI, 8'h00);
        wr(`CCA_CNT_LO, 8'h00);
        wr(`CCA_RUN_CTL, 8'h01);
        repeat (40) @(posedge clock);
        wr(`CCA_RUN_CTL, 8'h00);
        rd(`CCA_IRQ_STATUS, 8'h03, 8'h03);
        `CHK(cmp_out[1:0], 2'b10)
        // high byte FF on the 8-bit channel tells the two widths apart
        wr(`CCA_CNT_LO, 8'h10);
        repeat (3) @(posedge clock);
        `CHK(cmp_out[3:2], 2'b11)
        wr(`CCA_CNT_LO, 8'h90);
        repeat (3) @(posedge clock);
        `CHK(cmp_out[3:2], 2'b10)
        for (int i = 0; i < 4; i++)
            wr(ctl_a[i], 8'h00);
        repeat (3) @(posedge clock);
        `CHK(cmp_out, 4'h0)
        wr(`CCA_IRQ_CLEAR, 8'h0F);
        $display("test compare and pwm done");

        // each source runs about ten counts; a wrong source lands outside 8..15
        for (int s = 0; s < 4; s++) begin
            wr(`CCA_CNT_HI, 8'h00);
            wr(`CCA_CNT_LO, 8'h00);
            wr(`CCA_RUN_CTL, {5'h00, 2'(s), 1'b1});
            pins.ext_en <= (s == 3);
            repeat (cyc[s]) @(posedge clock);
            wr(`CCA_RUN_CTL, 8'h00);
            pins.ext_en <= 1'b0;
            repeat (10) @(posedge clock);
            rd(`CCA_CNT_LO, 8'h08, 8'hF8);
        end
        $display("test clock select done");
        repeat (4) @(posedge clock);
        tally_and_finish;
    end
endmodule
